// >>> rtl/ssf_consts.vh
// Constants for the system status flag bank
`ifndef SSF_CONSTS_VH
`define SSF_CONSTS_VH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define SSF_OFS_STATUS 8'h00
`define SSF_OFS_CTRL 8'h04
`define SSF_OFS_CDATA0 8'h08
`define SSF_OFS_CDATA1 8'h0c
`define SSF_OFS_CDATA2 8'h10
`define SSF_OFS_CDATA3 8'h14
`define SSF_OFS_WDT_CAUSE 8'h18

// ----------------------------------------
// Status register bit positions
// ----------------------------------------
`define SSF_ST_FUSE 0
`define SSF_ST_DIP 1
`define SSF_ST_BAT_LIVE 2
`define SSF_ST_BAT_LATCH 3
`define SSF_ST_SELF_DIAG 4
`define SSF_ST_DIAG 5
`define SSF_ST_CLK_ERR 6
`define SSF_ST_ONE 7
`define SSF_ST_ZERO 8
`define SSF_ST_WDT 9
`define SSF_ST_READY 10
`define SSF_ST_TEST 11

// ----------------------------------------
// Control register bit positions
// ----------------------------------------
`define SSF_CT_SET_REQ 0
`define SSF_CT_READ_REQ 1
`define SSF_CT_DIAG_RST 2
`define SSF_CT_CTRL_READY 3
`define SSF_CT_EXT_BAT 4

// ----------------------------------------
// Reset values
// ----------------------------------------
`define SSF_RST_CTRL 5'h00
`define SSF_RST_CDATA 16'h0000
`define SSF_RST_CAUSE 8'h00

// ----------------------------------------
// Timing
// ----------------------------------------
`define SSF_CLK_PERIOD_NS 8
`define SSF_DIP_AC_MS 20
`define SSF_DIP_DC_MS 10
`define SSF_NS_PER_MS 1000000

`endif

// >>> rtl/ssf_flag_bank.v
// System status flag bank with a classic Wishbone register slave
`timescale 1ns/1ps
`include "ssf_consts.vh"

// Function
// - Latch fuse-failure flag, hold after recovery
// - Latch short supply dip; only power-up clears
// - Live battery-low follows battery voltage
// - Latched battery-low holds after voltage recovers
// - Battery flags update only with external battery
// - Battery lamp follows battery-low flag
// - Latch self-diagnostic error flag
// - Latch diagnostic error flag
// - Reset request rising edge clears diagnostic error
// - Set request rising edge writes clock element if all words are BCD
// - Invalid clock words at set raise error
// - Read request high copies BCD time in
// - Constant-one flag always high
// - Constant-zero flag always low
// - Latch motion-processor watchdog error flag
// - Watchdog error stops all axes three clock cycles after the pin rises
// - Watchdog error stores its cause code
// - Ready rise sets complete flag if check passes
// - Ready low clears complete flag
// - Test-mode flag follows peripheral test mode
module ssf_flag_bank #(
    parameter DIP_AC_CYC = `SSF_DIP_AC_MS * `SSF_NS_PER_MS / `SSF_CLK_PERIOD_NS,
    parameter DIP_DC_CYC = `SSF_DIP_DC_MS * `SSF_NS_PER_MS / `SSF_CLK_PERIOD_NS
) (
    input wire clk_i,
    input wire rst_b_i,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [7:0] wb_adr_i,
    input wire [31:0] wb_dat_i,
    input wire [3:0] wb_sel_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    input wire fuse_blown_i,
    input wire supply_low_i,
    input wire supply_dc_i,
    input wire battery_low_i,
    input wire self_diag_err_i,
    input wire diag_err_i,
    input wire wdt_err_i,
    input wire test_mode_i,
    input wire [7:0] wdt_cause_i,
    input wire param_ok_i,
    input wire [63:0] rtc_time_i,
    output reg rtc_we_o,
    output reg [63:0] rtc_wdata_o,
    output reg battery_lamp_o,
    output reg axis_stop_o
);

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    localparam NSYNC = 8;
    wire [NSYNC-1:0] pin_raw;
    wire [NSYNC-1:0] pin_s;
    assign pin_raw = {supply_dc_i, test_mode_i, wdt_err_i, diag_err_i, self_diag_err_i,
                      battery_low_i, supply_low_i, fuse_blown_i};

    genvar gi;
    generate
        for (gi = 0; gi < NSYNC; gi = gi + 1)
        begin : g_sync
            reg meta_q;
            reg sync_q;
            always @(posedge clk_i or negedge rst_b_i)
            begin
                if (!rst_b_i)
                begin
                    meta_q <= 1'b0;
                    sync_q <= 1'b0;
                end
                else
                begin
                    meta_q <= pin_raw[gi];
                    sync_q <= meta_q;
                end
            end
            assign pin_s[gi] = sync_q;
        end
    endgenerate

    wire fuse_s = pin_s[0];
    wire supply_low_s = pin_s[1];
    wire bat_low_s = pin_s[2];
    wire self_diag_s = pin_s[3];
    wire diag_s = pin_s[4];
    wire wdt_s = pin_s[5];
    wire test_s = pin_s[6];
    wire dc_s = pin_s[7];

    // ----------------------------------------
    // Register state
    // ----------------------------------------
    reg fuse_fail_flag_q;
    reg supply_dip_flag_q;
    reg battery_low_live_flag_q;
    reg battery_low_latched_flag_q;
    reg self_diag_error_flag_q;
    reg diag_error_flag_q;
    reg clock_data_error_flag_q;
    reg motion_watchdog_error_flag_q;
    reg motion_ready_complete_flag_q;
    reg test_mode_active_flag_q;
    reg [4:0] ctrl_q;
    reg [4:0] ctrl_prev_q;
    wire [63:0] cdata_words;
    reg [7:0] wdt_cause_q;
    reg supply_low_prev_q;
    reg [21:0] dip_cnt_q;

    wire clock_set_request = ctrl_q[`SSF_CT_SET_REQ];
    wire clock_read_request = ctrl_q[`SSF_CT_READ_REQ];
    wire diag_error_reset_request = ctrl_q[`SSF_CT_DIAG_RST];
    wire controller_ready_input = ctrl_q[`SSF_CT_CTRL_READY];
    wire ext_bat_en = ctrl_q[`SSF_CT_EXT_BAT];

    wire set_rise = clock_set_request & ~ctrl_prev_q[`SSF_CT_SET_REQ];
    wire rst_rise = diag_error_reset_request & ~ctrl_prev_q[`SSF_CT_DIAG_RST];
    wire rdy_rise = controller_ready_input & ~ctrl_prev_q[`SSF_CT_CTRL_READY];

    // ----------------------------------------
    // Bus decode
    // ----------------------------------------
    wire bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire bus_wr = bus_req & wb_we_i;

    // Every nibble must be a BCD digit
    reg cdata_valid;
    integer ni;
    always @*
    begin
        cdata_valid = 1'b1;
        for (ni = 0; ni < 16; ni = ni + 1)
        begin
            if (cdata_words[ni*4 +: 4] > 4'h9)
                cdata_valid = 1'b0;
        end
    end

    // ----------------------------------------
    // Supply dip length measurement
    // ----------------------------------------
    // Counter saturates so a long outage never wraps into a short one
    wire [21:0] dip_limit = dc_s ? DIP_DC_CYC[21:0] : DIP_AC_CYC[21:0];
    wire dip_end = supply_low_prev_q & ~supply_low_s;

    always @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            supply_low_prev_q <= 1'b0;
            dip_cnt_q <= 22'h000000;
        end
        else
        begin
            supply_low_prev_q <= supply_low_s;
            if (!supply_low_s)
                dip_cnt_q <= 22'h000000;
            else if (dip_cnt_q != 22'h3fffff)
                dip_cnt_q <= dip_cnt_q + 22'h000001;
        end
    end

    // ----------------------------------------
    // Status flags
    // ----------------------------------------
    always @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            fuse_fail_flag_q <= 1'b0;
            supply_dip_flag_q <= 1'b0;
            self_diag_error_flag_q <= 1'b0;
            diag_error_flag_q <= 1'b0;
            clock_data_error_flag_q <= 1'b0;
            motion_ready_complete_flag_q <= 1'b0;
            test_mode_active_flag_q <= 1'b0;
        end
        else
        begin
            if (fuse_s)
                fuse_fail_flag_q <= 1'b1;
            // Cleared only by power-up reset
            if (dip_end && (dip_cnt_q < dip_limit))
                supply_dip_flag_q <= 1'b1;
            if (self_diag_s)
                self_diag_error_flag_q <= 1'b1;
            // A fresh error wins over the reset edge
            if (diag_s)
                diag_error_flag_q <= 1'b1;
            else if (rst_rise)
                diag_error_flag_q <= 1'b0;
            if (set_rise)
                clock_data_error_flag_q <= ~cdata_valid;
            if (!controller_ready_input)
                motion_ready_complete_flag_q <= 1'b0;
            else if (rdy_rise && param_ok_i)
                motion_ready_complete_flag_q <= 1'b1;
            test_mode_active_flag_q <= test_s;
        end
    end

    // ----------------------------------------
    // Battery monitor
    // ----------------------------------------
    always @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            battery_low_live_flag_q <= 1'b0;
            battery_low_latched_flag_q <= 1'b0;
            battery_lamp_o <= 1'b0;
        end
        else
        begin
            if (ext_bat_en)
            begin
                battery_low_live_flag_q <= bat_low_s;
                if (bat_low_s)
                    battery_low_latched_flag_q <= 1'b1;
            end
            // Lamp lags its flag by one cycle
            battery_lamp_o <= battery_low_latched_flag_q | battery_low_live_flag_q;
        end
    end

    // ----------------------------------------
    // Watchdog error and axis stop
    // ----------------------------------------
    // Only the first cause is kept, so a later error cannot hide the original fault
    always @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            motion_watchdog_error_flag_q <= 1'b0;
            wdt_cause_q <= `SSF_RST_CAUSE;
            axis_stop_o <= 1'b0;
        end
        else if (wdt_s)
        begin
            if (!motion_watchdog_error_flag_q)
                wdt_cause_q <= wdt_cause_i;
            motion_watchdog_error_flag_q <= 1'b1;
            axis_stop_o <= 1'b1;
        end
    end

    // ----------------------------------------
    // Clock element write port
    // ----------------------------------------
    always @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            rtc_we_o <= 1'b0;
            rtc_wdata_o <= 64'h0000000000000000;
        end
        else
        begin
            rtc_we_o <= set_rise & cdata_valid;
            if (set_rise)
                rtc_wdata_o <= cdata_words;
        end
    end

    // ----------------------------------------
    // Control register and edge history
    // ----------------------------------------
    always @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            ctrl_q <= `SSF_RST_CTRL;
            ctrl_prev_q <= `SSF_RST_CTRL;
        end
        else
        begin
            ctrl_prev_q <= ctrl_q;
            if (bus_wr && wb_sel_i[0] && (wb_adr_i == `SSF_OFS_CTRL))
                ctrl_q <= wb_dat_i[4:0];
        end
    end

    // ----------------------------------------
    // Clock data words
    // ----------------------------------------
    generate
        for (gi = 0; gi < 4; gi = gi + 1)
        begin : g_cdata
            localparam [31:0] OFS_W = `SSF_OFS_CDATA0 + 4 * gi;
            wire [7:0] ofs = OFS_W[7:0];
            reg [15:0] word_q;
            always @(posedge clk_i or negedge rst_b_i)
            begin
                if (!rst_b_i)
                    word_q <= `SSF_RST_CDATA;
                else if (clock_read_request)
                    // Live copy wins over software writes
                    word_q <= rtc_time_i[gi*16 +: 16];
                else if (bus_wr && (wb_adr_i == ofs))
                begin
                    if (wb_sel_i[0])
                        word_q[7:0] <= wb_dat_i[7:0];
                    if (wb_sel_i[1])
                        word_q[15:8] <= wb_dat_i[15:8];
                end
            end
            assign cdata_words[gi*16 +: 16] = word_q;
        end
    endgenerate

    // ----------------------------------------
    // Read mux and acknowledge
    // ----------------------------------------
    reg [31:0] rd_mux;
    always @*
    begin
        rd_mux = 32'h00000000;
        case (wb_adr_i)
            `SSF_OFS_STATUS:
            begin
                rd_mux[`SSF_ST_FUSE] = fuse_fail_flag_q;
                rd_mux[`SSF_ST_DIP] = supply_dip_flag_q;
                rd_mux[`SSF_ST_BAT_LIVE] = battery_low_live_flag_q;
                rd_mux[`SSF_ST_BAT_LATCH] = battery_low_latched_flag_q;
                rd_mux[`SSF_ST_SELF_DIAG] = self_diag_error_flag_q;
                rd_mux[`SSF_ST_DIAG] = diag_error_flag_q;
                rd_mux[`SSF_ST_CLK_ERR] = clock_data_error_flag_q;
                rd_mux[`SSF_ST_ONE] = 1'b1;
                rd_mux[`SSF_ST_ZERO] = 1'b0;
                rd_mux[`SSF_ST_WDT] = motion_watchdog_error_flag_q;
                rd_mux[`SSF_ST_READY] = motion_ready_complete_flag_q;
                rd_mux[`SSF_ST_TEST] = test_mode_active_flag_q;
            end
            `SSF_OFS_CTRL:
                rd_mux[4:0] = ctrl_q;
            `SSF_OFS_CDATA0:
                rd_mux[15:0] = cdata_words[15:0];
            `SSF_OFS_CDATA1:
                rd_mux[15:0] = cdata_words[31:16];
            `SSF_OFS_CDATA2:
                rd_mux[15:0] = cdata_words[47:32];
            `SSF_OFS_CDATA3:
                rd_mux[15:0] = cdata_words[63:48];
            `SSF_OFS_WDT_CAUSE:
                rd_mux[7:0] = wdt_cause_q;
            default:
                rd_mux = 32'h00000000;
        endcase
    end

    // Unmapped addresses ack with zero so a stray access never hangs
    always @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end
        else
        begin
            wb_ack_o <= bus_req;
            if (bus_req && !wb_we_i)
                wb_dat_o <= rd_mux;
        end
    end

endmodule

// >>> tb/ssf_flag_bank_props.sv
// Port-level assertions for the status flag bank
`timescale 1ns/1ps
`include "ssf_consts.vh"
module ssf_flag_bank_props (
    input wire clk_i,
    input wire rst_b_i,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [7:0] wb_adr_i,
    input wire [31:0] wb_dat_o,
    input wire wb_ack_o,
    input wire wdt_err_i,
    input wire rtc_we_o,
    input wire [63:0] rtc_wdata_o,
    input wire battery_lamp_o,
    input wire axis_stop_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_b_i);

    function automatic logic bcd(input logic [63:0] v);
        bcd = 1'b1;
        for (int i = 0; i < 16; i++)
            if (v[i*4 +: 4] > 4'h9)
                bcd = 1'b0;
    endfunction

    ack_timing_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack late");
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    unmapped_zero_a: assert property (wb_ack_o && !wb_we_i && wb_adr_i > `SSF_OFS_WDT_CAUSE |-> wb_dat_o == 32'h0)
        else $error("unmapped read not zero");
    const_bits_a: assert property (wb_ack_o && !wb_we_i && wb_adr_i == `SSF_OFS_STATUS |->
        wb_dat_o[`SSF_ST_ONE] && !wb_dat_o[`SSF_ST_ZERO]) else $error("constant flags wrong");
    rtc_pulse_a: assert property (rtc_we_o |=> !rtc_we_o)
        else $error("clock write not a pulse");
    rtc_cause_a: assert property ($rose(rtc_we_o) |-> $past(wb_ack_o) || $past(wb_ack_o, 2) || $past(wb_ack_o, 3))
        else $error("clock write without bus write");
    rtc_bcd_a: assert property (rtc_we_o |-> bcd(rtc_wdata_o))
        else $error("invalid clock data written");
    stop_fast_a: assert property (wdt_err_i [*4] |-> ##[0:3] axis_stop_o)
        else $error("axes not stopped");
    stop_keep_a: assert property (axis_stop_o |=> axis_stop_o)
        else $error("axis stop released");
    quiet_rst_a: assert property ($rose(rst_b_i) |-> !axis_stop_o && !rtc_we_o && !battery_lamp_o)
        else $error("outputs active after reset");

    cover property (rtc_we_o);
    cover property ($rose(axis_stop_o));
    cover property (battery_lamp_o);
endmodule

// >>> tb/testbench.sv
// Self-checking testbench for the status flag bank
`timescale 1ns/1ps
`include "ssf_consts.vh"
module testbench;
    logic clk_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, param_ok_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00, wdt_cause_i = 8'h00, pins = 8'h00, c;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q;
    logic [3:0] wb_sel_i = 4'hf;
    logic wb_ack_o, rtc_we_o, battery_lamp_o, axis_stop_o;
    logic [63:0] rtc_time_i = 64'h0, rtc_wdata_o, w, cap;
    int n_fail = 0, checks = 0, k, n_we = 0, e_we = 0;

    ssf_flag_bank #(.DIP_AC_CYC(40), .DIP_DC_CYC(20)) dut_u (
        .clk_i(clk_i), .rst_b_i(rst_b_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .fuse_blown_i(pins[0]), .supply_low_i(pins[1]), .supply_dc_i(pins[2]), .battery_low_i(pins[3]),
        .self_diag_err_i(pins[4]), .diag_err_i(pins[5]), .wdt_err_i(pins[6]), .test_mode_i(pins[7]),
        .wdt_cause_i(wdt_cause_i), .param_ok_i(param_ok_i), .rtc_time_i(rtc_time_i), .rtc_we_o(rtc_we_o),
        .rtc_wdata_o(rtc_wdata_o), .battery_lamp_o(battery_lamp_o), .axis_stop_o(axis_stop_o));

    initial
        forever #4 clk_i = ~clk_i;

    // Pulse is too short for the bus tasks to see, so count it here
    always @(posedge clk_i)
        if (rtc_we_o === 1'b1)
        begin
            n_we++;
            cap = rtc_wdata_o;
        end

    function automatic logic bcd(input logic [63:0] v);
        bcd = 1'b1;
        for (int i = 0; i < 16; i++)
            if (v[i*4 +: 4] > 4'h9)
                bcd = 1'b0;
    endfunction

    task chk(input logic [63:0] g, input logic [63:0] e);
        checks++;
        if (g !== e)
        begin
            n_fail++;
            $display("mismatch t=%0t got %h exp %h", $time, g, e);
        end
    endtask

    task cy(input int n);
        repeat (n) @(posedge clk_i);
    endtask

    task bus(input logic we, input logic [7:0] a, input logic [31:0] d);
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, we, a, d};
        do
            @(posedge clk_i);
        while (wb_ack_o !== 1'b1);
        q = wb_dat_o;
        {wb_cyc_i, wb_stb_i} <= 2'b00;
        @(posedge clk_i);
    endtask

    task rd(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(q, e);
    endtask

    task rst;
        rst_b_i <= 1'b0;
        pins <= 8'h00;
        cy(4);
        rst_b_i <= 1'b1;
        cy(2);
    endtask

    task stop_test;
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    initial
    begin
        #200000;
        n_fail++;
        stop_test;
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial
    begin
        k = $urandom(32'h495ac57d);
        rst;
        rd(`SSF_OFS_STATUS, 32'h80);
        rd(`SSF_OFS_WDT_CAUSE, 32'h0);
        bus(1'b1, 8'h40, 32'hffffffff);
        rd(8'h40, 32'h0);
        bus(1'b1, `SSF_OFS_STATUS, 32'hffffffff);
        rd(`SSF_OFS_STATUS, 32'h80);
        // Dip lengths straddle both limits: 30 cycles is long for DC only
        for (k = 0; k < 4; k++)
        begin
            pins[2] <= k[1];
            cy(3);
            pins[1] <= 1'b1;
            cy(k[0] ? 10 : (k[1] ? 30 : 50));
            pins[1] <= 1'b0;
            cy(5);
            rd(`SSF_OFS_STATUS, k[0] ? 32'h82 : 32'h80);
            rst;
        end
        c = 8'($urandom) | 8'h01;
        wdt_cause_i <= c;
        pins <= 8'h71;
        cy(5);
        pins <= 8'h00;
        wdt_cause_i <= 8'h00;
        cy(4);
        chk(axis_stop_o, 1'b1);
        rd(`SSF_OFS_STATUS, 32'h2b1);
        rd(`SSF_OFS_WDT_CAUSE, c);
        bus(1'b1, `SSF_OFS_CTRL, 32'h4);
        rd(`SSF_OFS_STATUS, 32'h291);
        pins[3] <= 1'b1;
        cy(5);
        rd(`SSF_OFS_STATUS, 32'h291);
        chk(battery_lamp_o, 1'b0);
        bus(1'b1, `SSF_OFS_CTRL, 32'h10);
        cy(4);
        rd(`SSF_OFS_STATUS, 32'h29d);
        chk(battery_lamp_o, 1'b1);
        pins[3] <= 1'b0;
        cy(5);
        rd(`SSF_OFS_STATUS, 32'h299);
        chk(battery_lamp_o, 1'b1);
        pins[7] <= 1'b1;
        cy(5);
        rd(`SSF_OFS_STATUS, 32'ha99);
        pins[7] <= 1'b0;
        cy(5);
        rd(`SSF_OFS_STATUS, 32'h299);
        param_ok_i <= 1'b1;
        bus(1'b1, `SSF_OFS_CTRL, 32'h18);
        rd(`SSF_OFS_STATUS, 32'h699);
        bus(1'b1, `SSF_OFS_CTRL, 32'h10);
        rd(`SSF_OFS_STATUS, 32'h299);
        param_ok_i <= 1'b0;
        bus(1'b1, `SSF_OFS_CTRL, 32'h18);
        rd(`SSF_OFS_STATUS, 32'h299);
        for (k = 0; k < 4; k++)
        begin
            for (int i = 0; i < 16; i++)
                w[i*4 +: 4] = 4'($urandom % 10);
            if (k == 2)
                w[63:60] = 4'ha;
            for (int i = 0; i < 4; i++)
                bus(1'b1, `SSF_OFS_CDATA0 + 8'(i * 4), {16'h0, w[i*16 +: 16]});
            bus(1'b1, `SSF_OFS_CTRL, 32'h11);
            cy(4);
            e_we += bcd(w);
            chk(n_we, e_we);
            if (bcd(w))
                chk(cap, w);
            chk(rtc_wdata_o, w);
            bus(1'b1, `SSF_OFS_CTRL, 32'h10);
            rd(`SSF_OFS_STATUS, bcd(w) ? 32'h299 : 32'h2d9);
        end
        // Flip each digit's low bit: still BCD, but unlike what the words hold now
        w ^= 64'h1111111111111111;
        rtc_time_i <= w;
        bus(1'b1, `SSF_OFS_CTRL, 32'h12);
        cy(2);
        for (int i = 0; i < 4; i++)
            rd(`SSF_OFS_CDATA0 + 8'(i * 4), {16'h0, w[i*16 +: 16]});
        stop_test;
    end
endmodule

bind ssf_flag_bank ssf_flag_bank_props chk_u (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wdt_err_i(wdt_err_i), .rtc_we_o(rtc_we_o),
    .rtc_wdata_o(rtc_wdata_o), .battery_lamp_o(battery_lamp_o), .axis_stop_o(axis_stop_o));
